// ### hdl/tone_pkg.sv
// constants shared by the tone generator and its waveform divider
// Contract
// R1: with output enabled, the tone waveform drives the pin continuously.
// R2: output disabled and no burst active keeps the pin low.
// R3: waveform runs free of enable writes; truncated edge pulses are allowed.
// R4: tone is an integer division of the low-speed oscillator rate.
// R5: pitch code 0..7 gives 4096.0 down to 1170.3 Hz.
// R6: duty is high time over whole period.
// R7: level code 0 is level 1 (max duty), code 7 level 8 (min).
// R8: high time is 9-n of 16/20 steps, 13-n of 24/28 steps.
// R9: with fade on, envelope level replaces the level select field.
// R10: fade on adds the envelope to continuous output; off keeps duty fixed.
// R11: envelope starts at level 1 on output start, steps to 8, holds.
// R12: fade restart during envelope output returns duty to level 1.
// R13: envelope step lasts 62.5 ms (select 0) or 125 ms (select 1).
// R14: first envelope step may be up to 4 ms off, free divider.
// R15: burst length selects between exactly two durations.
// R16: burst trigger starts and ends tone aligned to the 256 Hz tick.
// R17: reading the trigger bit shows 1 while a burst is busy.
// R18: burst stop ends a burst early, aligned to the 256 Hz tick.
// R19: trigger during a burst restarts the full duration at next tick.
// R20: bursts use selected pitch and fixed level, never the envelope.
// R21: burst triggers are ignored while continuous output is enabled.
// R22: software must set the pin as output, data 0, pulldown off.
// R23: burst length 1 gives 125 ms, 0 gives 31.25 ms.
// R24: fade restart does nothing without envelope and tone output.
// R25: burst stop does nothing unless a burst is in progress.
// R26: fade restart and burst stop always read back as 0.
// R27: burst lasts 8 ticks (short) or 32 ticks (long) of 256 Hz.
// R28: reset clears all tone control bits to 0.
package tone_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BURST_OFS = 8'h04;
   localparam logic [7:0] PITCH_OFS = 8'h08;
   localparam logic [7:0] LEVEL_OFS = 8'h0C;
   localparam logic [7:0] STATUS_OFS = 8'h10;
   // control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FADE_BIT = 1;
   localparam int CTRL_RESTART_BIT = 2;
   localparam int CTRL_STEPSEL_BIT = 3;
   // burst register fields
   localparam int BURST_LEN_BIT = 0;
   localparam int BURST_TRIG_BIT = 1;
   localparam int BURST_STOP_BIT = 2;
   // reset values of all control fields
   localparam logic CTRL_RST = 1'b0;
   localparam logic [2:0] CODE_RST = 3'h0;
   // rates: tone steps at twice the 32.768 kHz oscillator
   localparam int OSC_HZ = 32768;
   localparam int STEP_HZ = 2 * OSC_HZ;
   localparam int CLK_HZ = 200000000;
   localparam int TICK_HZ = 256;
   // times in microseconds, as printed
   localparam int ENV_FAST_US = 62500;
   localparam int ENV_SLOW_US = 125000;
   localparam int BURST_SHORT_US = 31250;
   localparam int BURST_LONG_US = 125000;
   // derived step and tick counts
   localparam int TICK_STEPS = STEP_HZ / TICK_HZ;
   localparam int ENV_FAST_STEPS = (STEP_HZ / 64) * ENV_FAST_US / 15625;
   localparam int ENV_SLOW_STEPS = (STEP_HZ / 64) * ENV_SLOW_US / 15625;
   localparam int BURST_SHORT_TICKS = BURST_SHORT_US * TICK_HZ / 1000000;
   localparam int BURST_LONG_TICKS = BURST_LONG_US * TICK_HZ / 1000000;
   localparam logic [12:0] TICK_MASK = 13'(TICK_STEPS - 1);
   localparam logic [12:0] ENV_FAST_MASK = 13'(ENV_FAST_STEPS - 1);
   localparam logic [12:0] ENV_SLOW_MASK = 13'(ENV_SLOW_STEPS - 1);
   // waveform shape: period 16 + 4*code[1:0] steps, high base 8 or 12
   localparam logic [4:0] PERIOD_BASE = 5'h10;
   localparam logic [4:0] HIGH_SHORT = 5'h08;
   localparam logic [4:0] HIGH_LONG = 5'h0C;
   localparam logic [2:0] LEVEL_MIN = 3'h7;
endpackage

// ### hdl/tone_wave.sv
// tone waveform divider: pitch sets period, level sets high time
`timescale 1ns/1ps
module tone_wave (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // step enable at twice the oscillator rate
   input wire logic step_en,
   // selections
   input wire logic [2:0] pitch,
   input wire logic [2:0] level,
   // waveform
   output logic wave
);
   typedef struct packed {
      logic half;
      logic [4:0] phase;
      logic wave;
   } wave_s;

   wave_s s_q;
   wave_s s_d;
   logic adv;
   logic [4:0] period;
   logic [4:0] high;

   // shape from the selections; pitch 4..7 halve the step rate
   always_comb begin
      period = tone_pkg::PERIOD_BASE + {1'b0, pitch[1:0], 2'b00}; // see R4
      high = (pitch[1] ? tone_pkg::HIGH_LONG : tone_pkg::HIGH_SHORT)
         - {2'b00, level}; // see R8
      adv = step_en & (~pitch[2] | s_q.half);
      s_d = s_q;
      if (step_en & pitch[2]) begin
         s_d.half = ~s_q.half;
      end
      // wrap also catches a phase left past a shortened period
      if (adv) begin
         if (s_q.phase >= period - 5'h01) begin
            s_d.phase = 5'h00;
         end else begin
            s_d.phase = s_q.phase + 5'h01;
         end
      end
      s_d.wave = s_d.phase < high; // see R6
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wave = s_q.wave;
endmodule

// ### hdl/tone_gen.sv
// buzzer tone generator with envelope and one-shot burst, APB slave
`timescale 1ns/1ps
module tone_gen #(
   parameter int CLK_HZ = tone_pkg::CLK_HZ
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // tone output pin
   output logic TONE_PIN
);
   typedef struct packed {
      // software controls
      logic tone_output_enable;
      logic fade_on;
      logic fade_step_time_select;
      logic burst_length_select;
      logic [2:0] tone_pitch_select;
      logic [2:0] tone_level_select;
      // oscillator rate accumulator and step pulse
      logic [31:0] acc;
      logic step_en;
      // free-running timebase in steps
      logic [12:0] tb;
      // envelope
      logic enable_prev;
      logic [2:0] env_level;
      logic [5:0] env_cnt;
      // one-shot burst
      logic burst_act;
      logic start_pend;
      logic stop_pend;
      logic [5:0] burst_cnt;
      // pin and bus answer
      logic pin;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } gen_s;

   gen_s s_q;
   gen_s s_d;
   logic wave;
   logic [2:0] eff_level;
   logic [2:0] wave_level;
   logic fade_active;
   logic bus_done;
   logic wr;
   logic rd_setup;
   logic hit;
   logic [31:0] rd_val;
   logic tick256;
   logic env_tick;
   logic [5:0] env_last;
   logic [32:0] acc_sum;
   logic trig_wr;
   logic stop_wr;
   logic restart_wr;
   logic out_start;

   localparam logic [32:0] ACC_STEP = 33'(tone_pkg::STEP_HZ);
   localparam logic [32:0] ACC_MOD = 33'(CLK_HZ);
   // envelope step length in 256 Hz ticks, minus one
   localparam logic [5:0] ENV_FAST_LAST =
      6'(tone_pkg::ENV_FAST_STEPS / tone_pkg::TICK_STEPS - 1);
   localparam logic [5:0] ENV_SLOW_LAST =
      6'(tone_pkg::ENV_SLOW_STEPS / tone_pkg::TICK_STEPS - 1);

   // waveform divider; bursts take the fixed level, never the envelope
   tone_wave u_wave (
      .clk(CLK),
      .rst(RST),
      .step_en(s_q.step_en),
      .pitch(s_q.tone_pitch_select),
      .level(wave_level),
      .wave(wave)
   );

   // envelope only shapes continuous output
   always_comb begin
      fade_active = s_q.fade_on & s_q.tone_output_enable;
      eff_level = fade_active ? s_q.env_level
         : s_q.tone_level_select; // see R9
      wave_level = s_q.burst_act ? s_q.tone_level_select
         : eff_level; // see R20
   end

   // bus decode; a write lands at the edge that completes the access
   always_comb begin
      bus_done = PSEL & PENABLE & s_q.pready;
      wr = bus_done & PWRITE;
      rd_setup = PSEL & PENABLE & ~s_q.pready;
      hit = (PADDR == tone_pkg::CTRL_OFS) | (PADDR == tone_pkg::BURST_OFS)
         | (PADDR == tone_pkg::PITCH_OFS) | (PADDR == tone_pkg::LEVEL_OFS)
         | (PADDR == tone_pkg::STATUS_OFS);
   end

   // decoded write strobes for the pulse bits
   always_comb begin
      trig_wr = wr & (PADDR == tone_pkg::BURST_OFS)
         & PWDATA[tone_pkg::BURST_TRIG_BIT]
         & ~s_q.tone_output_enable; // see R21
      stop_wr = wr & (PADDR == tone_pkg::BURST_OFS)
         & PWDATA[tone_pkg::BURST_STOP_BIT]
         & (s_q.burst_act | s_q.start_pend); // see R25
      restart_wr = wr & (PADDR == tone_pkg::CTRL_OFS)
         & PWDATA[tone_pkg::CTRL_RESTART_BIT]
         & fade_active; // see R12, R24
   end

   // read mux; pulse-only bits always read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (PADDR)
         tone_pkg::CTRL_OFS: begin
            rd_val[tone_pkg::CTRL_EN_BIT] = s_q.tone_output_enable;
            rd_val[tone_pkg::CTRL_FADE_BIT] = s_q.fade_on;
            rd_val[tone_pkg::CTRL_RESTART_BIT] = 1'b0; // see R26
            rd_val[tone_pkg::CTRL_STEPSEL_BIT] = s_q.fade_step_time_select;
         end
         tone_pkg::BURST_OFS: begin
            rd_val[tone_pkg::BURST_LEN_BIT] = s_q.burst_length_select;
            rd_val[tone_pkg::BURST_TRIG_BIT] = s_q.burst_act
               | s_q.start_pend; // see R17
            rd_val[tone_pkg::BURST_STOP_BIT] = 1'b0; // see R26
         end
         tone_pkg::PITCH_OFS: begin
            rd_val[2:0] = s_q.tone_pitch_select;
         end
         tone_pkg::LEVEL_OFS: begin
            rd_val[2:0] = s_q.tone_level_select;
         end
         tone_pkg::STATUS_OFS: begin
            rd_val[2:0] = wave_level;
            rd_val[3] = s_q.burst_act;
            rd_val[4] = s_q.pin;
         end
         default: begin
            rd_val = 32'h0000_0000;
         end
      endcase
   end

   // timebase strobes; envelope steps count ticks from output start,
   // so only the free tick phase shifts the first step, under 4 ms
   always_comb begin
      tick256 = s_q.step_en
         & ((s_q.tb & tone_pkg::TICK_MASK) == tone_pkg::TICK_MASK);
      env_last = s_q.fade_step_time_select ? ENV_SLOW_LAST
         : ENV_FAST_LAST; // see R13
      // compare not equal: a rate change mid-step must not wrap
      env_tick = fade_active & tick256
         & (s_q.env_cnt >= env_last); // see R14
      out_start = s_q.tone_output_enable & ~s_q.enable_prev;
      acc_sum = {1'b0, s_q.acc} + ACC_STEP;
   end

   // next state
   always_comb begin
      s_d = s_q;

      // fractional divider: average rate of twice the oscillator
      if (acc_sum >= ACC_MOD) begin
         s_d.acc = 32'(acc_sum - ACC_MOD);
         s_d.step_en = 1'b1; // see R4
      end else begin
         s_d.acc = acc_sum[31:0];
         s_d.step_en = 1'b0;
      end

      // free-running timebase, never reset by software
      if (s_q.step_en) begin
         s_d.tb = s_q.tb + 13'h0001;
      end

      // bus answer: one wait state, data captured before completion
      s_d.pready = 1'b0;
      if (rd_setup) begin
         s_d.pready = 1'b1;
         s_d.pslverr = ~hit;
         s_d.prdata = PWRITE ? 32'h0000_0000 : rd_val;
      end

      // control, burst, pitch and level register writes
      if (wr & (PADDR == tone_pkg::CTRL_OFS)) begin
         s_d.tone_output_enable = PWDATA[tone_pkg::CTRL_EN_BIT];
         s_d.fade_on = PWDATA[tone_pkg::CTRL_FADE_BIT]; // see R10
         s_d.fade_step_time_select = PWDATA[tone_pkg::CTRL_STEPSEL_BIT];
      end
      if (wr & (PADDR == tone_pkg::BURST_OFS)) begin
         s_d.burst_length_select = PWDATA[tone_pkg::BURST_LEN_BIT];
      end
      if (wr & (PADDR == tone_pkg::PITCH_OFS)) begin
         s_d.tone_pitch_select = PWDATA[2:0]; // see R5
      end
      if (wr & (PADDR == tone_pkg::LEVEL_OFS)) begin
         s_d.tone_level_select = PWDATA[2:0]; // see R7
      end

      // envelope: restart at level 1, step down, hold at level 8
      s_d.enable_prev = s_q.tone_output_enable;
      if (out_start | restart_wr) begin
         s_d.env_level = 3'h0; // see R11, R12
         s_d.env_cnt = 6'h00;
      end else if (fade_active & tick256) begin
         s_d.env_cnt = env_tick ? 6'h00 : s_q.env_cnt + 6'h01;
         if (env_tick & (s_q.env_level != tone_pkg::LEVEL_MIN)) begin
            s_d.env_level = s_q.env_level + 3'h1; // see R11
         end
      end

      // burst on the 256 Hz tick: start, stop or run out
      if (tick256) begin
         s_d.stop_pend = 1'b0;
         if (s_q.start_pend) begin
            s_d.start_pend = 1'b0;
            s_d.burst_act = 1'b1; // see R16, R19
            s_d.burst_cnt = s_q.burst_length_select
               ? 6'(tone_pkg::BURST_LONG_TICKS)
               : 6'(tone_pkg::BURST_SHORT_TICKS); // see R15, R23, R27
         end else if (s_q.burst_act
            & (s_q.stop_pend | (s_q.burst_cnt == 6'h01))) begin
            s_d.burst_act = 1'b0; // see R16, R18
            s_d.burst_cnt = 6'h00;
         end else if (s_q.burst_act) begin
            s_d.burst_cnt = s_q.burst_cnt - 6'h01;
         end
      end

      // requests after the tick so a same-cycle write is kept
      if (trig_wr) begin
         s_d.start_pend = 1'b1; // see R19
         s_d.stop_pend = 1'b0;
      end
      if (stop_wr) begin
         s_d.start_pend = 1'b0;
         s_d.stop_pend = s_d.burst_act | s_q.burst_act; // see R18
      end

      // pin gating is not aligned to the waveform, glitches allowed
      s_d.pin = wave & (s_q.tone_output_enable
         | s_q.burst_act); // see R1, R2, R3
   end

   // single state register; reset clears every control bit
   always_ff @(posedge CLK) begin
      if (RST) begin
         s_q <= '0;
         s_q.tone_output_enable <= tone_pkg::CTRL_RST; // see R28
         s_q.tone_pitch_select <= tone_pkg::CODE_RST;
         s_q.tone_level_select <= tone_pkg::CODE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the register
   assign PRDATA = s_q.prdata;
   assign PREADY = s_q.pready;
   assign PSLVERR = s_q.pslverr;
   assign TONE_PIN = s_q.pin;
endmodule

// ### tb/tone_gen_monitor.sv
// port checker for the tone generator
`timescale 1ns/1ps
module tone_gen_monitor #(
   parameter int CLK_HZ = tone_pkg::CLK_HZ
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // tone pin
   input wire logic TONE_PIN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // exactly one wait state, answer one cycle wide
   a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("ready not after one wait state");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (PREADY |-> PSEL && $past(PENABLE))
      else $error("ready without access phase");
   // unmapped places answer with an error and no data
   a_err_unmapped: assert property (PREADY && PADDR > tone_pkg::STATUS_OFS
      |-> PSLVERR) else $error("unmapped address without error");
   a_err_mapped: assert property (PREADY && PADDR[1:0] == 2'h0 &&
      PADDR <= tone_pkg::STATUS_OFS |-> !PSLVERR)
      else $error("error on mapped address");
   a_err_data: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
      else $error("data with error answer");
   // write-only bits never read back set
   a_wo_ctrl: assert property (
      PREADY && !PWRITE && PADDR == tone_pkg::CTRL_OFS
      |-> !PRDATA[tone_pkg::CTRL_RESTART_BIT]) else $error("restart reads 1");
   a_wo_burst: assert property (
      PREADY && !PWRITE && PADDR == tone_pkg::BURST_OFS
      |-> !PRDATA[tone_pkg::BURST_STOP_BIT]) else $error("stop reads 1");
   a_reset_quiet: assert property (
      $past(RST) |-> !TONE_PIN && !PREADY)
      else $error("pin or ready active after reset");
endmodule
bind tone_gen tone_gen_monitor #(.CLK_HZ(CLK_HZ)) tone_gen_monitor_i (
   .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .TONE_PIN(TONE_PIN));

// ### tb/buzzer_model.sv
// piezo buzzer model that measures the tone pin waveform
`timescale 1ns/1ps
module buzzer_model (
   // measuring clock
   input wire logic clk,
   // pin set up as plain output, data 0, no pull-down
   input wire logic pin,
   // last full period, its high time, count of rising edges
   output int high_n,
   output int period_n,
   output int rises
);
   int cnt = 0;
   int hc = 0;
   logic last = 1'b0;
   initial begin
      high_n = 0;
      period_n = 0;
      rises = 0;
   end
   // each rising edge closes one period; first one may be truncated
   always @(posedge clk) begin
      if (pin === 1'b1 && last !== 1'b1) begin
         period_n <= cnt;
         high_n <= hc;
         rises <= rises + 1;
         cnt = 1;
         hc = 1;
      end else begin
         cnt = cnt + 1;
         if (pin === 1'b1) hc = hc + 1;
      end
      last <= pin;
   end
endmodule

// ### tb/tone_gen_bench.sv
// self-checking bench for the tone generator
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
   n_errors++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tone_gen_bench;
   // five clocks per tone step keeps the run short
   localparam int HZ = 327680;
   localparam int ST = HZ / tone_pkg::STEP_HZ;
   localparam int TK = tone_pkg::TICK_STEPS * ST;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA, rd, e, m;
   logic PREADY, PSLVERR, TONE_PIN, err;
   logic [2:0] r;
   logic [31:0] expq[$];
   logic [31:0] mskq[$];
   int n_errors = 0;
   int check_count = 0;
   int cyc = 0;
   int hi, per, rises, c0, h, p2, dt;
   always #2.5 CLK = ~CLK;
   always @(posedge CLK) cyc <= cyc + 1;
   tone_gen #(.CLK_HZ(HZ)) tone_gen_i (.CLK(CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .TONE_PIN(TONE_PIN));
   buzzer_model buzzer_model_i (.clk(CLK), .pin(TONE_PIN), .high_n(hi),
      .period_n(per), .rises(rises));
   // oldest noted read against each answer; mask 0 means poll only
   always @(posedge CLK) begin
      if (PREADY === 1'b1 && PWRITE === 1'b0 && mskq.size() > 0) begin
         e = expq.pop_front();
         m = mskq.pop_front();
         if (m !== 32'h0) `CHK("read", e & m, PRDATA & m)
      end
   end
   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tmo(input logic hit);
      if (hit) begin
         n_errors++;
         wrap_up();
      end
   endtask
   // apb transfer held until ready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int k;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      k = 0;
      do begin
         @(posedge CLK);
         k++;
      end while (PREADY !== 1'b1 && k < 20);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      tmo(k >= 20);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] x,
         input logic [31:0] k);
      expq.push_back(x);
      mskq.push_back(k);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic waitr(input int n);
      int r0, k;
      r0 = rises;
      k = 0;
      while (rises < r0 + n && k < 5000) begin
         @(posedge CLK);
         k++;
      end
      tmo(k >= 5000);
   endtask
   // poll the busy bit until the burst has ended
   task automatic poll;
      int k;
      k = 0;
      do begin
         rdx(tone_pkg::BURST_OFS, 32'h0, 32'h0);
         k++;
      end while (rd[1] !== 1'b0 && k < 6000);
      tmo(k >= 6000);
   endtask
   initial begin
      void'($urandom(15772));
      repeat (4) @(posedge CLK);
      RST <= 1'b0;
      rdx(tone_pkg::CTRL_OFS, 32'h0, 32'hF);
      rdx(tone_pkg::BURST_OFS, 32'h0, 32'h7);
      rdx(tone_pkg::PITCH_OFS, 32'h0, 32'h7);
      rdx(tone_pkg::LEVEL_OFS, 32'h0, 32'h7);
      rdx(8'h14, 32'h0, 32'hFFFFFFFF);
      `CHK("slverr", 1'b1, err)
      // every pitch, levels permuted by a random pattern
      r = 3'($urandom);
      wr(tone_pkg::CTRL_OFS, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(tone_pkg::PITCH_OFS, 32'(i));
         wr(tone_pkg::LEVEL_OFS, 32'(i ^ r));
         waitr(3);
         h = ((i & 2) != 0 ? 12 : 8) - (i ^ r);
         p2 = (i > 3) ? 2 * ST : ST;
         `CHK("period", (16 + 4 * (i & 3)) * p2, per)
         `CHK("high", h * p2, hi)
      end
      // output off leaves the pin quiet
      wr(tone_pkg::CTRL_OFS, 32'h0);
      repeat (300) @(posedge CLK);
      c0 = rises;
      repeat (300) @(posedge CLK);
      `CHK("quiet", c0, rises)
      // envelope starts at level 1, steps once, restart returns
      c0 = cyc;
      wr(tone_pkg::CTRL_OFS, 32'h3);
      waitr(3);
      `CHK("fade high", 24 * ST, hi)
      do rdx(tone_pkg::STATUS_OFS, 32'h0, 32'h0);
      while (rd[2:0] === 3'h0 && cyc - c0 < 25000);
      `CHK("step", 3'h1, rd[2:0])
      dt = cyc - c0;
      `CHK("step time", 1'b1, dt > 15 * TK && dt <= 16 * TK + 40)
      wr(tone_pkg::CTRL_OFS, 32'h7);
      rdx(tone_pkg::STATUS_OFS, 32'h0, 32'h7);
      rdx(tone_pkg::CTRL_OFS, 32'h3, 32'hF);
      // short burst with fade on keeps the fixed level
      wr(tone_pkg::LEVEL_OFS, 32'h5);
      wr(tone_pkg::CTRL_OFS, 32'h2);
      c0 = cyc;
      wr(tone_pkg::BURST_OFS, 32'h2);
      rdx(tone_pkg::BURST_OFS, 32'h2, 32'h7);
      poll();
      dt = cyc - c0;
      `CHK("short", 1'b1, dt > 8 * TK && dt <= 9 * TK + 40)
      `CHK("burst high", 14 * ST, hi)
      // retrigger extends the burst
      c0 = cyc;
      wr(tone_pkg::BURST_OFS, 32'h2);
      repeat (5 * TK) @(posedge CLK);
      wr(tone_pkg::BURST_OFS, 32'h2);
      poll();
      dt = cyc - c0;
      `CHK("retrig", 1'b1, dt > 13 * TK && dt <= 14 * TK + 40)
      // stop ends a long burst at the next tick
      wr(tone_pkg::BURST_OFS, 32'h3);
      repeat (3 * TK) @(posedge CLK);
      c0 = cyc;
      wr(tone_pkg::BURST_OFS, 32'h5);
      poll();
      `CHK("stop", 1'b1, cyc - c0 <= TK + 40)
      `CHK("pin off", 1'b0, TONE_PIN)
      wr(tone_pkg::BURST_OFS, 32'h5);
      rdx(tone_pkg::BURST_OFS, 32'h1, 32'h7);
      // trigger refused while continuous output runs
      wr(tone_pkg::CTRL_OFS, 32'h1);
      wr(tone_pkg::BURST_OFS, 32'h3);
      rdx(tone_pkg::BURST_OFS, 32'h1, 32'h7);
      wrap_up();
   end
endmodule
